// ===== hw/wfs_pkg.sv
// package for the waveform sequencer slot block: register map, field layout, timing
// assumes a 40 MHz system clock and an apb slave with 32-bit data
package wfs_pkg;
  localparam int unsigned WFS_CLK_HZ = 40_000_000;
  localparam int unsigned WFS_STEP_MS = 10;
  localparam int unsigned WFS_STEP_CYC = WFS_CLK_HZ / 1000 * WFS_STEP_MS;
  localparam int unsigned WFS_SLOT_COUNT = 8;
  // printed offsets are not all multiples of four: they are word indices
  localparam logic [7:0] WFS_IDX_CONTROL = 8'h0c;
  localparam logic [7:0] WFS_IDX_SLOT_FIRST = 8'h0f;
  localparam logic [7:0] WFS_IDX_SLOT_LAST = 8'h16;
  localparam logic [7:0] WFS_IDX_SLOT_FOUR = 8'h12;
  localparam logic [7:0] WFS_IDX_SLOT_FIVE = 8'h13;
  localparam logic [7:0] WFS_IDX_STATUS = 8'h20;
  localparam int unsigned WFS_FLAG_BIT = 7;
  localparam int unsigned WFS_START_BIT = 0;
  localparam logic [7:0] WFS_SLOT_RESET = 8'h00;
  localparam logic [6:0] WFS_END_MARK = 7'h00;
  typedef enum logic [1:0] {
    WFS_IDLE,
    WFS_FETCH,
    WFS_PLAY,
    WFS_PAUSE
  } wfs_state_e;
endpackage : wfs_pkg

// ===== hw/wfs_waveform_sequencer_slots.sv
// waveform sequencer with eight apb-mapped sequence slots (slots four and five included)
// assumes an external drive engine that plays an effect index and reports completion
// Operation
// - a slot with its delay flag set idles for ten milliseconds times its 7-bit value.
// - a slot with its delay flag clear holds a 7-bit waveform identifier to play.
// - the identifier is presented as the integer index into the waveform library.
// - setting the start bit of the control register starts playback at the first slot.
// - when a waveform finishes the sequencer takes the next slot and plays it if nonzero.
// - playback stops at an entry whose 7-bit value is zero, delay flag or not, or after all eight slots, whichever comes first.
module wfs_waveform_sequencer_slots #(
  parameter int unsigned STEP_CYCLES = wfs_pkg::WFS_STEP_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [6:0] effectIndex,
  output logic effectPlay,
  input wire logic effectDone,
  output logic seqBusy
);
  import wfs_pkg::*;

  initial begin
    if (STEP_CYCLES < 1) $error("STEP_CYCLES must be at least one");
  end

  localparam int unsigned SW = $clog2(WFS_SLOT_COUNT);

  logic [7:0] slotReg [WFS_SLOT_COUNT];
  wfs_state_e stateReg;
  logic [SW-1:0] slotPtrReg;
  logic [31:0] tickCntReg;
  logic [6:0] stepCntReg;
  logic startReg;

  logic [7:0] wordIdx;
  logic accSetup;
  logic slotHit;
  logic [SW-1:0] slotSel;
  logic ctrlHit;
  logic statHit;
  logic [7:0] curSlot;
  logic lastSlot;

  assign wordIdx = paddr[9:2];
  assign accSetup = psel && !penable;
  assign slotHit = (wordIdx >= WFS_IDX_SLOT_FIRST) && (wordIdx <= WFS_IDX_SLOT_LAST);
  assign slotSel = SW'(wordIdx - WFS_IDX_SLOT_FIRST);
  assign ctrlHit = (wordIdx == WFS_IDX_CONTROL);
  assign statHit = (wordIdx == WFS_IDX_STATUS);
  assign curSlot = slotReg[slotPtrReg];
  assign lastSlot = (slotPtrReg == SW'(WFS_SLOT_COUNT - 1));

  // no wait state: the answer is registered in the setup cycle, pready in the first access cycle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= accSetup;
      if (accSetup) begin
        pslverr <= !(slotHit || ctrlHit || statHit);
        prdata <= 32'h0000_0000;
        if (!pwrite) begin
          if (slotHit) prdata <= {24'h00_0000, slotReg[slotSel]};
          else if (ctrlHit) prdata <= {31'h0000_0000, startReg};
          else if (statHit) prdata <= {31'h0000_0000, seqBusy};
        end
      end
    end
  end

  // slots are only written by software; the sequencer never alters them
  genvar gi;
  generate
    for (gi = 0; gi < WFS_SLOT_COUNT; gi++) begin : gSlot
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          slotReg[gi] <= WFS_SLOT_RESET;
        end else if (psel && penable && pready && pwrite && slotHit
                     && slotSel == SW'(gi)) begin
          slotReg[gi] <= pwdata[7:0];
        end
      end
    end
  endgenerate

  // start bit reads as one until the sequencer picks it up
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      startReg <= 1'b0;
    end else if (psel && penable && pready && pwrite && ctrlHit) begin
      startReg <= pwdata[WFS_START_BIT] || startReg;
    end else if (stateReg == WFS_IDLE && startReg) begin
      startReg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stateReg <= WFS_IDLE;
      slotPtrReg <= '0;
      tickCntReg <= 32'h0000_0000;
      stepCntReg <= 7'h00;
      effectIndex <= 7'h00;
      effectPlay <= 1'b0;
      seqBusy <= 1'b0;
    end else begin
      effectPlay <= 1'b0;
      case (stateReg)
        WFS_IDLE: begin
          seqBusy <= 1'b0;
          if (startReg) begin
            slotPtrReg <= '0;
            stateReg <= WFS_FETCH;
            seqBusy <= 1'b1;
          end
        end
        WFS_FETCH: begin
          if (curSlot[6:0] == WFS_END_MARK) begin
            stateReg <= WFS_IDLE;
            seqBusy <= 1'b0;
          end else if (curSlot[WFS_FLAG_BIT]) begin
            stepCntReg <= curSlot[6:0];
            tickCntReg <= 32'h0000_0000;
            stateReg <= WFS_PAUSE;
          end else begin
            effectIndex <= curSlot[6:0];
            effectPlay <= 1'b1;
            stateReg <= WFS_PLAY;
          end
        end
        WFS_PLAY, WFS_PAUSE: begin
          logic done;
          done = 1'b0;
          if (stateReg == WFS_PLAY) begin
            done = effectDone;
          end else if (tickCntReg == STEP_CYCLES - 1) begin
            tickCntReg <= 32'h0000_0000;
            stepCntReg <= stepCntReg - 7'h01;
            done = (stepCntReg == 7'h01);
          end else begin
            tickCntReg <= tickCntReg + 32'h0000_0001;
          end
          if (done) begin
            if (lastSlot) begin
              stateReg <= WFS_IDLE;
              seqBusy <= 1'b0;
            end else begin
              slotPtrReg <= slotPtrReg + SW'(1);
              stateReg <= WFS_FETCH;
            end
          end
        end
        default: begin
          stateReg <= WFS_IDLE;
        end
      endcase
    end
  end
endmodule : wfs_waveform_sequencer_slots

// ===== verification/wfs_props.sv
// checker: port relations of the sequencer slot block
// assumes only the top module's ports, one clock
module wfs_props (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic effectPlay,
  input wire logic effectDone,
  input wire logic seqBusy
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence go_s;
    psel && penable && pready && pwrite && paddr == 32'h30 && pwdata[0];
  endsequence
  AST_READY: assert property (setup_s |=> pready) else $error("ready late");
  AST_START: assert property (go_s |-> ##[1:3] seqBusy) else $error("no start");
  AST_PLAY_BUSY: assert property (effectPlay |-> seqBusy) else $error("idle play");
  // a new play needs done, then a fetch cycle; with done one cycle after play, as the bench drives it, two quiet cycles follow a pulse
  AST_NEXT: assert property (effectPlay |=> !effectPlay [*2])
    else $error("early play");
  AST_READY_PULSE: assert property (pready |=> !pready) else $error("long ready");
  AST_STOP: assert property ($fell(seqBusy) |-> !effectPlay) else $error("late play");
endmodule : wfs_props
bind wfs_waveform_sequencer_slots wfs_props i_props (.clk_sys, .nrst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .effectPlay, .effectDone, .seqBusy);

// ===== verification/wfs_waveform_sequencer_slots_tb.sv
// bench: apb access to the slots and sequence playback
// assumes the bench itself plays the drive engine, done one cycle after play
module wfs_waveform_sequencer_slots_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import wfs_pkg::*;
  logic clk_sys = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, effectDone = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, r;
  logic pready, pslverr, effectPlay, seqBusy, e;
  logic [6:0] effectIndex;
  logic [6:0] got[$];
  int at[$];
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  wfs_waveform_sequencer_slots #(.STEP_CYCLES(4)) i_dut (.clk_sys, .nrst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .effectIndex, .effectPlay,
    .effectDone, .seqBusy);
  initial forever #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    effectDone <= effectPlay;
    if (effectPlay) begin
      got.push_back(effectIndex);
      at.push_back(cyc);
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= {22'h0, i, 2'h0};
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20) chk(0, 1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk_sys);
  endtask : apb
  task automatic play(input int n);
    int k;
    k = 0;
    got.delete();
    at.delete();
    apb(1, WFS_IDX_CONTROL, 32'h1);
    while (seqBusy !== 1'b1 && k++ < 5) @(posedge clk_sys);
    chk(seqBusy, 1);
    while (seqBusy !== 1'b0 && k++ < 500) @(posedge clk_sys);
    chk(seqBusy, 0);
    chk(got.size(), n);
    apb(0, WFS_IDX_STATUS, 0);
    chk(r, 0);
  endtask : play
  task automatic t_regs;
    apb(0, WFS_IDX_SLOT_FOUR, 0);
    chk(r, 0);
    apb(1, WFS_IDX_SLOT_FOUR, 32'h85);
    apb(1, WFS_IDX_SLOT_FIVE, 32'h2a);
    apb(0, WFS_IDX_SLOT_FOUR, 0);
    chk(r, 32'h85);
    apb(0, WFS_IDX_SLOT_FIVE, 0);
    chk(r, 32'h2a);
    apb(0, 8'h3f, 0);
    chk(r, 0);
    chk(e, 1);
    $display("test regs done");
  endtask : t_regs
  task automatic t_delay;
    apb(1, 8'h0f, 32'h05);
    apb(1, 8'h10, 32'h82);
    apb(1, 8'h11, 32'h07);
    apb(1, 8'h12, 32'h00);
    play(2);
    chk({got[0], got[1]}, {7'h05, 7'h07});
    // two steps of four cycles, plus done and fetch overhead of a few cycles
    chk(at[1] - at[0] >= 8, 1);
    chk(at[1] - at[0] <= 16, 1);
    apb(0, 8'h10, 0);
    chk(r, 32'h82);
    $display("test delay done");
  endtask : t_delay
  task automatic t_full;
    for (int i = 0; i < 8; i++) apb(1, WFS_IDX_SLOT_FIRST + 8'(i), 32'(i + 9));
    play(8);
    for (int i = 0; i < 8; i++) chk(got[i], 32'(i + 9));
    $display("test full done");
  endtask : t_full
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize
  initial begin
    #100us;
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    nrst <= 1;
    @(posedge clk_sys);
    t_regs();
    t_delay();
    t_full();
    summarize();
  end
endmodule : wfs_waveform_sequencer_slots_tb
